// File: rtl/ulm_dev.sv
// Transceiver end: bus register access, alternate bus modes and resistor decode
//
// Notes on behaviour
// - Low power: DATA3 carries active-high event flag
// - Low power: DATA2 and DATA7..4 driven low
// - Six-wire select bit written enters six-wire
// - Stop signal leaves six-wire, back to sync
// - Six-wire: link drives enable, level, zero
// - Six-wire: receive lines out, DATA7 low
// - Three-wire select bit written enters three-wire
// - Stop signal leaves three-wire, back to sync
// - Three-wire DATA1 shared differential, direction by enable
// - Three-wire DATA2 shared zero, direction by enable
// - Three-wire: enable from DATA0, event DATA3
// - Clock runs in serial modes only if kept
// - Resistor enables decoded from the mode fields
// - Pull-up, pull-downs, termination each own output
// - Host suspend: pull-downs on, others off
// - Host resume: pull-downs on, others off
// - Link programs the operating-state fields; a stop exit sets the low-power bit and clears both select bits
// - Direction held high in low power and serial
// - Clearing low-power bit enters low-power mode
`timescale 1ns/1ps
`default_nettype none

module ulm_dev (
  input wire logic REF_CLK,
  input wire logic RST,
  ulm_if.dev_mp BUS,
  input wire logic PLUS_LINE_RX,
  input wire logic MINUS_LINE_RX,
  input wire logic DIFF_RX_LEVEL,
  input wire logic ZERO_RX,
  input wire logic EVENT_FLAG_IN,
  output logic SERIAL_TX_DRIVE,
  output logic SERIAL_TX_LEVEL,
  output logic SERIAL_TX_ZERO_FORCE,
  output logic PLUS_PULLUP_ON,
  output logic PLUS_PULLDOWN_ON,
  output logic MINUS_PULLDOWN_ON,
  output logic FAST_TERMINATION_ON,
  output logic CLOCK_RUN
);

  // ==========================================================================
  // State
  typedef struct packed {
    ulm_pkg::ulm_dev_e st;
    logic [7:0] func;
    logic [7:0] intf;
    logic [7:0] otg;
    logic [5:0] addr;
    logic [3:0] rx1;
    logic [3:0] rx2;
    logic ev1;
    logic ev2;
    logic [7:0] dout;
    logic [2:0] tx;
    logic [3:0] res;
  } ulm_dev_s;

  ulm_dev_s q;
  ulm_dev_s d;
  logic [7:0] rd_val;
  logic [1:0] opm;
  logic serial;

  // ==========================================================================
  // Register read mux
  always_comb begin
    case (q.addr)
      ulm_pkg::FUNC_ADDR: rd_val = q.func;
      ulm_pkg::INTF_ADDR: rd_val = q.intf;
      ulm_pkg::OTG_ADDR: rd_val = q.otg;
      default: rd_val = 8'h00;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    opm = 2'h0;
    // Line receivers and the event source are asynchronous to REF_CLK
    d.rx1 = {ZERO_RX, DIFF_RX_LEVEL, MINUS_LINE_RX, PLUS_LINE_RX};
    d.rx2 = q.rx1;
    d.ev1 = EVENT_FLAG_IN;
    d.ev2 = q.ev1;

    // Transmit controls are registered off the link-driven lines, one cycle behind them
    case (q.st)
      ulm_pkg::D_SIX: d.tx = BUS.data[2:0];
      ulm_pkg::D_THREE: d.tx = BUS.data[0] ? BUS.data[2:0] : 3'h0;
      default: d.tx = 3'h0;
    endcase

    case (q.st)
      ulm_pkg::D_IDLE: begin
        if (BUS.data[7:6] == ulm_pkg::CMD_WR) begin
          d.addr = BUS.data[5:0];
          d.st = ulm_pkg::D_WDATA;
        end else if (BUS.data[7:6] == ulm_pkg::CMD_RD) begin
          d.addr = BUS.data[5:0];
          d.st = ulm_pkg::D_RTURN;
        end
      end
      ulm_pkg::D_WDATA: begin
        // The fields are taken as written; the device changes them itself only on a stop exit from a mode
        case (q.addr)
          ulm_pkg::FUNC_ADDR: d.func = BUS.data;
          ulm_pkg::INTF_ADDR: d.intf = BUS.data;
          ulm_pkg::OTG_ADDR: d.otg = BUS.data;
          default: d.func = q.func;
        endcase
        d.st = ulm_pkg::D_WSTP;
      end
      ulm_pkg::D_WSTP: begin
        d.st = ulm_pkg::D_IDLE;
        // Mode change takes effect once the write is closed by stop
        if (BUS.stp) begin
          if (!q.func[ulm_pkg::LPN_BIT]) begin
            d.st = ulm_pkg::D_LOWPWR;
          end else if (q.intf[ulm_pkg::SIX_BIT]) begin
            d.st = ulm_pkg::D_SIX;
          end else if (q.intf[ulm_pkg::THREE_BIT]) begin
            d.st = ulm_pkg::D_THREE;
          end
        end
      end
      ulm_pkg::D_RTURN: d.st = ulm_pkg::D_RDATA;
      ulm_pkg::D_RDATA: d.st = ulm_pkg::D_IDLE;
      ulm_pkg::D_LOWPWR, ulm_pkg::D_SIX, ulm_pkg::D_THREE: begin
        if (BUS.stp) begin
          d.st = ulm_pkg::D_IDLE;
          d.func[ulm_pkg::LPN_BIT] = 1'b1;
          d.intf[ulm_pkg::SIX_BIT] = 1'b0;
          d.intf[ulm_pkg::THREE_BIT] = 1'b0;
        end
      end
      default: d.st = ulm_pkg::D_IDLE;
    endcase

    // Bus byte for the coming cycle, picked by the state it will be in
    case (d.st)
      ulm_pkg::D_RDATA: d.dout = rd_val;
      ulm_pkg::D_LOWPWR: d.dout = {4'h0, q.ev2, 1'b0, q.rx2[1], q.rx2[0]};
      ulm_pkg::D_SIX: d.dout = {1'b0, q.rx2[2], q.rx2[1], q.rx2[0], q.ev2, 3'h0};
      ulm_pkg::D_THREE: d.dout = {4'h0, q.ev2, q.rx2[3], q.rx2[2], 1'b0};
      default: d.dout = 8'h00;
    endcase

    // Resistor decode works on the field values of the coming cycle
    opm = d.func[ulm_pkg::OPM_LSB +: 2];
    if (opm == ulm_pkg::OPM_TRISTATE) begin
      d.res = 4'h0;
    end else begin
      d.res[3] = d.func[ulm_pkg::TERM_BIT] & ~d.otg[ulm_pkg::PPD_BIT];
      d.res[2] = d.otg[ulm_pkg::PPD_BIT];
      d.res[1] = d.otg[ulm_pkg::MPD_BIT];
      d.res[0] = (d.func[ulm_pkg::SPD_LSB +: 2] == ulm_pkg::SPD_HS) &
                 ~d.func[ulm_pkg::TERM_BIT];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      q <= '{st: ulm_pkg::D_IDLE, func: ulm_pkg::FUNC_RST, intf: ulm_pkg::INTF_RST,
             otg: ulm_pkg::OTG_RST, addr: 6'h00, rx1: 4'h0, rx2: 4'h0, ev1: 1'b0,
             ev2: 1'b0, dout: 8'h00, tx: 3'h0, res: 4'h0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Bus and analog outputs
  assign serial = (q.st == ulm_pkg::D_SIX) || (q.st == ulm_pkg::D_THREE);

  assign BUS.dir = (q.st == ulm_pkg::D_RTURN) || (q.st == ulm_pkg::D_RDATA) ||
                   (q.st == ulm_pkg::D_LOWPWR) || serial;
  assign BUS.dev_dout = q.dout;

  // Shared lines turn around with the link's enable in the same cycle to avoid a fight
  always_comb begin
    case (q.st)
      ulm_pkg::D_RDATA: BUS.dev_oe = 8'hff;
      ulm_pkg::D_LOWPWR: BUS.dev_oe = 8'hff;
      ulm_pkg::D_SIX: BUS.dev_oe = 8'hf8;
      ulm_pkg::D_THREE: BUS.dev_oe = BUS.data[0] ? 8'hf8 : 8'hfe;
      default: BUS.dev_oe = 8'h00;
    endcase
  end

  assign SERIAL_TX_DRIVE = q.tx[0];
  assign SERIAL_TX_LEVEL = q.tx[1];
  assign SERIAL_TX_ZERO_FORCE = q.tx[2];

  assign PLUS_PULLUP_ON = q.res[3];
  assign PLUS_PULLDOWN_ON = q.res[2];
  assign MINUS_PULLDOWN_ON = q.res[1];
  assign FAST_TERMINATION_ON = q.res[0];

  // Clock stops in low power, and in serial modes unless the link asked to keep it
  assign CLOCK_RUN = (q.st != ulm_pkg::D_LOWPWR) &&
                     !(serial && !q.intf[ulm_pkg::KEEPCLK_BIT]);

endmodule

`default_nettype wire

// File: include/ulm_pkg.sv
// Shared constants and types for the low-pin transceiver bus and its alternate modes
package ulm_pkg;

  // ==========================================================================
  // Device register addresses on the bus
  localparam logic [5:0] FUNC_ADDR = 6'h04;
  localparam logic [5:0] INTF_ADDR = 6'h07;
  localparam logic [5:0] OTG_ADDR = 6'h0a;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] FUNC_RST = 8'h41;
  localparam logic [7:0] INTF_RST = 8'h00;
  localparam logic [7:0] OTG_RST = 8'h06;

  // ==========================================================================
  // Field positions
  localparam int SPD_LSB = 0;
  localparam int TERM_BIT = 2;
  localparam int OPM_LSB = 3;
  localparam int LPN_BIT = 6;
  localparam int SIX_BIT = 0;
  localparam int THREE_BIT = 1;
  localparam int KEEPCLK_BIT = 3;
  localparam int PPD_BIT = 1;
  localparam int MPD_BIT = 2;
  localparam int ACC_RD_BIT = 15;

  // ==========================================================================
  // Field codes
  localparam logic [1:0] OPM_TRISTATE = 2'h1;
  localparam logic [1:0] SPD_HS = 2'h0;
  localparam logic [1:0] CMD_WR = 2'h2;
  localparam logic [1:0] CMD_RD = 2'h3;

  // ==========================================================================
  // Link controller software register addresses
  localparam logic [3:0] SW_ACCESS = 4'h0;
  localparam logic [3:0] SW_STATUS = 4'h1;
  localparam logic [3:0] SW_SERTX = 4'h2;
  localparam logic [3:0] SW_WAKE = 4'h3;

  // ==========================================================================
  // State machines
  typedef enum logic [3:0] {
    D_IDLE, D_WDATA, D_WSTP, D_RTURN, D_RDATA, D_LOWPWR, D_SIX, D_THREE
  } ulm_dev_e;

  typedef enum logic [3:0] {
    L_IDLE, L_WCMD, L_WDATA, L_WSTP, L_RCMD, L_RTURN, L_RDATA, L_WAKE
  } ulm_lnk_e;

endpackage

// File: include/ulm_if.sv
// Eight-line data bus with direction and stop between transceiver and link
`timescale 1ns/1ps
`default_nettype none

interface ulm_if;
  logic dir;
  logic stp;
  logic [7:0] dev_dout;
  logic [7:0] dev_oe;
  logic [7:0] lnk_dout;
  logic [7:0] lnk_oe;
  logic [7:0] data;

  // Device drive wins; an undriven line reads low
  assign data = (dev_oe & dev_dout) | (~dev_oe & lnk_oe & lnk_dout);

  modport dev_mp (
    output dir,
    output dev_dout,
    output dev_oe,
    input stp,
    input data
  );

  modport lnk_mp (
    output stp,
    output lnk_dout,
    output lnk_oe,
    input dir,
    input data
  );
endinterface

`default_nettype wire

// File: rtl/ulm_lnk.sv
// Link end: software registers, device register access, serial transmit and wake
`timescale 1ns/1ps
`default_nettype none

module ulm_lnk (
  input wire logic REF_CLK,
  input wire logic RST,
  ulm_if.lnk_mp BUS,
  input wire logic [3:0] SW_ADDR,
  input wire logic [31:0] SW_WDATA,
  input wire logic SW_WR,
  input wire logic SW_RD,
  output logic [31:0] SW_RDATA
);

  // ==========================================================================
  // State
  typedef struct packed {
    ulm_pkg::ulm_lnk_e st;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic [7:0] dout;
    logic six;
    logic three;
    logic [2:0] tx;
    logic [7:0] rd;
    logic [31:0] rdata;
  } ulm_lnk_s;

  ulm_lnk_s q;
  ulm_lnk_s d;
  logic busy;

  assign busy = (q.st != ulm_pkg::L_IDLE);

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    d.rdata = 32'h0;

    case (q.st)
      ulm_pkg::L_WCMD: d.st = ulm_pkg::L_WDATA;
      ulm_pkg::L_WDATA: begin
        d.st = ulm_pkg::L_WSTP;
        // Track the serial mode asked for, to know which lines to drive
        if (q.waddr == ulm_pkg::INTF_ADDR) begin
          d.six = q.wdata[ulm_pkg::SIX_BIT];
          d.three = q.wdata[ulm_pkg::THREE_BIT];
        end
      end
      ulm_pkg::L_WSTP: d.st = ulm_pkg::L_IDLE;
      ulm_pkg::L_RCMD: d.st = ulm_pkg::L_RTURN;
      ulm_pkg::L_RTURN: d.st = ulm_pkg::L_RDATA;
      ulm_pkg::L_RDATA: begin
        d.rd = BUS.data;
        d.st = ulm_pkg::L_IDLE;
      end
      ulm_pkg::L_WAKE: begin
        // Stop stays high until the device hands the bus back
        if (!BUS.dir) begin
          d.st = ulm_pkg::L_IDLE;
          d.six = 1'b0;
          d.three = 1'b0;
        end
      end
      default: d.st = ulm_pkg::L_IDLE;
    endcase

    if (SW_WR) begin
      case (SW_ADDR)
        ulm_pkg::SW_ACCESS: begin
          // Refused while busy or while the device owns the bus
          if (!busy && !BUS.dir) begin
            d.waddr = SW_WDATA[13:8];
            d.wdata = SW_WDATA[7:0];
            d.st = SW_WDATA[ulm_pkg::ACC_RD_BIT] ? ulm_pkg::L_RCMD : ulm_pkg::L_WCMD;
          end
        end
        ulm_pkg::SW_SERTX: d.tx = SW_WDATA[2:0];
        ulm_pkg::SW_WAKE: begin
          if (SW_WDATA[0] && !busy && BUS.dir) begin
            d.st = ulm_pkg::L_WAKE;
          end
        end
        default: d.tx = q.tx;
      endcase
    end

    if (SW_RD) begin
      case (SW_ADDR)
        ulm_pkg::SW_STATUS: d.rdata = {8'h00, BUS.data, q.rd, 3'h0, BUS.stp, q.six,
                                       q.three, BUS.dir, busy};
        ulm_pkg::SW_SERTX: d.rdata = {29'h0, q.tx};
        default: d.rdata = 32'h0;
      endcase
    end

    case (d.st)
      ulm_pkg::L_WCMD: d.dout = {ulm_pkg::CMD_WR, d.waddr};
      ulm_pkg::L_WDATA: d.dout = q.wdata;
      ulm_pkg::L_RCMD: d.dout = {ulm_pkg::CMD_RD, d.waddr};
      ulm_pkg::L_IDLE: d.dout = {5'h00, d.tx};
      default: d.dout = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      q <= '{st: ulm_pkg::L_IDLE, waddr: 6'h00, wdata: 8'h00, dout: 8'h00, six: 1'b0,
             three: 1'b0, tx: 3'h0, rd: 8'h00, rdata: 32'h0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Bus outputs
  always_comb begin
    case (q.st)
      ulm_pkg::L_WCMD, ulm_pkg::L_WDATA, ulm_pkg::L_WSTP, ulm_pkg::L_RCMD: BUS.lnk_oe = 8'hff;
      ulm_pkg::L_IDLE: begin
        if (!BUS.dir) begin
          BUS.lnk_oe = 8'hff;
        end else if (q.six) begin
          BUS.lnk_oe = 8'h07;
        end else if (q.three) begin
          BUS.lnk_oe = q.tx[0] ? 8'h07 : 8'h01;
        end else begin
          BUS.lnk_oe = 8'h00;
        end
      end
      default: BUS.lnk_oe = 8'h00;
    endcase
  end

  assign BUS.lnk_dout = q.dout;
  assign BUS.stp = (q.st == ulm_pkg::L_WSTP) || (q.st == ulm_pkg::L_WAKE);
  assign SW_RDATA = q.rdata;

endmodule

`default_nettype wire

// File: dv/ulm_asserts.sv
// Bus-side checks between the transceiver and link ends
`timescale 1ns/1ps
`default_nettype none

module ulm_asserts (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic dir,
  input wire logic stp,
  input wire logic [7:0] dev_dout,
  input wire logic [7:0] dev_oe,
  input wire logic [7:0] lnk_dout,
  input wire logic [7:0] lnk_oe,
  input wire logic [7:0] data
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // ==========================================================================
  // Mode maps
  // Two full-drive cycles in a row set low power apart from a one-cycle read answer
  property p_lp_idle;
    dir && dev_oe == 8'hff && $past(dev_oe) == 8'hff |-> data[7:4] == 4'h0 && !data[2];
  endproperty
  a_lp_idle: assert property (p_lp_idle) else $error("idle lines not low");
  // Stop is left out: while waking, the link has already let go of its lines
  property p_six_map;
    dev_oe == 8'hf8 && !stp |-> dir && !data[7] && lnk_oe[2:0] == 3'h7;
  endproperty
  a_six_map: assert property (p_six_map) else $error("upper map wrong");
  property p_three_rx;
    dev_oe == 8'hfe && !stp |-> dir && data[7:4] == 4'h0 && !data[0] && lnk_oe[0];
  endproperty
  a_three_rx: assert property (p_three_rx)
    else $error("shared lines wrong");

  // ==========================================================================
  // Entry, hold and exit
  property p_hold;
    dir && $past(dir) && !stp && dev_oe[7:3] == 5'h1f && $past(dev_oe[7:3]) == 5'h1f |=> dir;
  endproperty
  a_hold: assert property (p_hold) else $error("direction dropped in mode");
  property p_wake;
    dir && $past(dir) && stp |=> !dir;
  endproperty
  a_wake: assert property (p_wake) else $error("stop did not end mode");
  property p_sync;
    !dir && !$past(dir) |-> lnk_oe == 8'hff && dev_oe == 8'h00;
  endproperty
  a_sync: assert property (p_sync) else $error("bus not synchronous");
  property p_six_in;
    data == 8'h87 && !dir ##1 data[0] ##1 stp |=> dir && dev_oe == 8'hf8;
  endproperty
  a_six_in: assert property (p_six_in) else $error("six-wire not entered");
  property p_three_in;
    data == 8'h87 && !dir ##1 data[1:0] == 2'b10 ##1 stp |=>
      dir && dev_oe[7:3] == 5'h1f && !dev_oe[0];
  endproperty
  a_three_in: assert property (p_three_in) else $error("three-wire not entered");
  property p_lp_in;
    data == 8'h84 && !dir ##1 !data[6] ##1 stp |=> dir && dev_oe == 8'hff;
  endproperty
  a_lp_in: assert property (p_lp_in) else $error("low power not entered");
endmodule

`default_nettype wire

// File: dv/ulm_tb.sv
// Testbench joining both ends, driven from the software port
`timescale 1ns/1ps
`default_nettype none

module ulm_tb;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic [4:0] rx = 5'h0;
  logic pr = 1'b0;
  logic rd_seen = 1'b0;
  logic sx_z, sx_l, sx_d, clk_run, pu, ppd, mpd, ft;
  logic [7:0] pv;
  logic [7:0] xr;
  logic [63:0] exq[$];
  logic [63:0] e;
  logic [1:0] spd, opm;
  logic t, a, b;
  logic [2:0] s;
  int n_errors = 0;
  int n_compared = 0;

  ulm_if bus_if ();
  ulm_dev ulm_dev_i (.REF_CLK(REF_CLK), .RST(RST), .BUS(bus_if), .PLUS_LINE_RX(rx[4]),
    .MINUS_LINE_RX(rx[3]), .DIFF_RX_LEVEL(rx[2]), .ZERO_RX(rx[1]), .EVENT_FLAG_IN(rx[0]),
    .SERIAL_TX_DRIVE(sx_d), .SERIAL_TX_LEVEL(sx_l), .SERIAL_TX_ZERO_FORCE(sx_z),
    .PLUS_PULLUP_ON(pu), .PLUS_PULLDOWN_ON(ppd), .MINUS_PULLDOWN_ON(mpd),
    .FAST_TERMINATION_ON(ft), .CLOCK_RUN(clk_run));
  ulm_lnk ulm_lnk_i (.REF_CLK(REF_CLK), .RST(RST), .BUS(bus_if), .SW_ADDR(sw_addr),
    .SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd), .SW_RDATA(sw_rdata));
  ulm_asserts ulm_asserts_i (.REF_CLK(REF_CLK), .RST(RST), .dir(bus_if.dir), .stp(bus_if.stp),
    .dev_dout(bus_if.dev_dout), .dev_oe(bus_if.dev_oe), .lnk_dout(bus_if.lnk_dout),
    .lnk_oe(bus_if.lnk_oe), .data(bus_if.data));

  assign pv = {sx_z, sx_l, sx_d, clk_run, pu, ppd, mpd, ft};

  initial begin
    forever #20 REF_CLK = ~REF_CLK;
  end

  // ==========================================================================
  // Checking and closing
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Each read answer or probe consumes the oldest note, masked to the fields it predicts
  always @(posedge REF_CLK) begin
    rd_seen <= sw_rd;
    if (rd_seen || pr) begin
      e = exq.pop_front();
      chk((rd_seen ? sw_rdata : {24'h0, pv}) & e[63:32], e[31:0]);
    end
  end

  // ==========================================================================
  // Software port drivers
  task sw(input logic [3:0] ad, input logic [31:0] d, input logic w);
    @(posedge REF_CLK);
    sw_addr <= ad;
    sw_wdata <= d;
    sw_wr <= w;
    sw_rd <= !w;
    @(posedge REF_CLK);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
  endtask

  // Fixed wait covers the three-cycle bus write and the receive sync lag
  task dwr(input logic [5:0] ad, input logic [7:0] d);
    sw(ulm_pkg::SW_ACCESS, {16'h0, 2'b00, ad, d}, 1'b1);
    repeat (6) @(posedge REF_CLK);
  endtask

  task rd_st(input logic [31:0] m, input logic [31:0] v);
    exq.push_back({m, v});
    sw(ulm_pkg::SW_STATUS, 32'h0, 1'b0);
  endtask

  task probe(input logic [7:0] m, input logic [7:0] v);
    exq.push_back({24'h0, m, 24'h0, v});
    @(posedge REF_CLK);
    pr <= 1'b1;
    @(posedge REF_CLK);
    pr <= 1'b0;
  endtask

  task sertx(input logic [2:0] v);
    sw(ulm_pkg::SW_SERTX, {29'h0, v}, 1'b1);
    repeat (6) @(posedge REF_CLK);
  endtask

  task wake;
    sw(ulm_pkg::SW_WAKE, 32'h1, 1'b1);
    repeat (6) @(posedge REF_CLK);
    rd_st(32'h2, 32'h0);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'hf4f288cd));
    repeat (12) @(posedge REF_CLK);
    RST <= 1'b0;
    // First two passes are the host suspend and resume rows, the rest random
    for (int i = 0; i < 14; i++) begin
      spd = i < 2 ? 2'h1 : 2'($urandom);
      t = i < 2 ? 1'b1 : 1'($urandom);
      opm = i < 2 ? {i[0], 1'b0} : 2'($urandom);
      {a, b} = i < 2 ? 2'b11 : 2'($urandom);
      dwr(ulm_pkg::FUNC_ADDR, {3'b010, opm, t, spd});
      dwr(ulm_pkg::OTG_ADDR, {5'h0, b, a, 1'b0});
      xr = opm == ulm_pkg::OPM_TRISTATE ? 8'h00 :
        {4'h0, t & ~a, a, b, spd == ulm_pkg::SPD_HS && !t};
      probe(8'h0f, xr);
    end
    // Read the pulldown request byte back through the bus read path
    sw(ulm_pkg::SW_ACCESS, {16'h0, 1'b1, 1'b0, ulm_pkg::OTG_ADDR, 8'h00}, 1'b1);
    repeat (6) @(posedge REF_CLK);
    rd_st(32'h0000ff00, {16'h0, 5'h0, b, a, 1'b0, 8'h00});
    for (int r = 0; r < 2; r++) begin
      rx <= {4'($urandom), r[0]};
      dwr(ulm_pkg::FUNC_ADDR, 8'h00);
      rd_st(32'h00ff0002, {8'h0, 4'h0, rx[0], 1'b0, rx[3], rx[4], 16'h2});
      wake;
      dwr(ulm_pkg::INTF_ADDR, 8'h01);
      s = 3'($urandom);
      sertx(s);
      rd_st(32'h00ff0002, {8'h0, 1'b0, rx[2], rx[3], rx[4], rx[0], s, 16'h2});
      probe(8'hf0, {s, 5'h0});
      wake;
      sertx(3'h0);
      dwr(ulm_pkg::INTF_ADDR, 8'h0a);
      rd_st(32'h00ff0002, {8'h0, 4'h0, rx[0], rx[1], rx[2], 1'b0, 16'h2});
      probe(8'hf0, 8'h10);
      s = {2'($urandom), 1'b1};
      sertx(s);
      rd_st(32'h00ff0002, {8'h0, 4'h0, rx[0], s, 16'h2});
      probe(8'hf0, {s, 5'h10});
      wake;
    end
    repeat (4) @(posedge REF_CLK);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge REF_CLK);
    n_errors++;
    end_of_test();
  end
endmodule

`default_nettype wire
